// File: pmca_pkg.sv
// Constants for the programmable macrocell array and its register map
// Behaviour
// - Ten dedicated inputs, eight pins, eight macrocells
// - Each pin set input, output or bidirectional
// - Eight 36-input product terms ORed per cell
// - Output and feedback pick comb/registered, polarity
// - Macrocell register is a plain D flip-flop
// - Erased cell: combinational active-low, pin feedback
// - Bits erase to one, program only to zero
// - Security bit programmed to zero blocks configuration readback
// - Erase opens the security bit and sets all array and control bits to one
package pmca_pkg;
   localparam int NUM_DED   = 10;
   localparam int NUM_MC    = 8;
   localparam int NUM_TERM  = 8;
   localparam int NUM_VAR   = NUM_DED + NUM_MC;
   localparam int TERM_W    = 2 * NUM_VAR;
   localparam int CTRL_W    = 7;
   localparam int MEM_DEPTH = NUM_MC * NUM_TERM;

   // Control word fields, each erases to one
   localparam int CTL_OUT_COMB = 0;
   localparam int CTL_OUT_LOW  = 1;
   localparam int CTL_FB_PIN   = 2;
   localparam int CTL_FB_COMB  = 3;
   localparam int CTL_FB_TRUE  = 4;
   localparam int CTL_MODE_LO  = 5;
   localparam int CTL_MODE_HI  = 6;

   // Word indices (byte address / 4)
   localparam logic [9:0] IDX_TERM_LAST = 10'h07F;
   localparam logic [9:0] IDX_CTRL_BASE = 10'h080;
   localparam logic [9:0] IDX_CTRL_LAST = 10'h087;
   localparam logic [9:0] IDX_CMD       = 10'h090;
   localparam logic [9:0] IDX_SECURE    = 10'h091;
   localparam logic [9:0] IDX_DYN_OE    = 10'h092;
   localparam logic [9:0] IDX_STATUS    = 10'h093;

   localparam int CMD_ERASE = 0;
   localparam logic [TERM_W-1:0] TERM_ERASED = {TERM_W{1'b1}};
   localparam logic [CTRL_W-1:0] CTRL_ERASED = {CTRL_W{1'b1}};
   localparam logic              SEC_ERASED  = 1'b1;
   localparam logic [NUM_MC-1:0] DYN_OE_RST  = 8'hFF;
endpackage

// File: pmca_macrocell.sv
// One macrocell: product terms, OR gate, D register, output selection
`timescale 1ns/1ps
module pmca_macrocell (
   input  wire logic                                    clk_i,    // Clock
   input  wire logic                                    rst_i,    // Sync reset
   input  wire logic [pmca_pkg::TERM_W-1:0]             lit_i,    // Literals
   input  wire logic [pmca_pkg::NUM_TERM*pmca_pkg::TERM_W-1:0] terms_i, // AND
   input  wire logic [pmca_pkg::CTRL_W-1:0]             ctrl_i,   // Control
   input  wire logic                                    reg_en_i, // Clock edge
   input  wire logic                                    pin_fb_i, // Pin level
   output logic                                         out_o,    // To pin
   output logic                                         fb_o      // To array
);
   logic [pmca_pkg::NUM_TERM-1:0] prod;
   logic                          sop;
   logic                          comb_q;
   logic                          reg_q;
   logic                          next_comb_q;
   logic                          next_reg_q;
   logic                          fb_raw;

   // A connected literal must be true; erased terms hold x and ~x, so read 0
   genvar t;
   generate
      for (t = 0; t < pmca_pkg::NUM_TERM; t++) begin : g_term
         assign prod[t] = &(~terms_i[t*pmca_pkg::TERM_W +: pmca_pkg::TERM_W]
                            | lit_i);
      end
   endgenerate

   assign sop = |prod;

   always_comb begin
      next_comb_q = sop;
      next_reg_q  = reg_en_i ? sop : reg_q;
   end

   // Comb path staged once per cycle so feedback never forms a loop
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         comb_q <= 1'b0;
         reg_q  <= 1'b0;
      end else begin
         comb_q <= next_comb_q;
         reg_q  <= next_reg_q;
      end
   end

   always_comb begin
      out_o  = (ctrl_i[pmca_pkg::CTL_OUT_COMB] ? comb_q : reg_q)
               ^ ctrl_i[pmca_pkg::CTL_OUT_LOW];
      fb_raw = ctrl_i[pmca_pkg::CTL_FB_COMB] ? comb_q : reg_q;
      if (ctrl_i[pmca_pkg::CTL_FB_PIN])
         fb_o = pin_fb_i;
      else
         fb_o = fb_raw ^ ~ctrl_i[pmca_pkg::CTL_FB_TRUE];
   end
endmodule

// File: pmca_top.sv
// Macrocell array top: pin sync, configuration store, Wishbone slave
//
// The Wishbone slave port and the address map were decided locally.
`timescale 1ns/1ps
module pmca_top (
   input  wire logic                         clk_i,     // 250 MHz clock
   input  wire logic                         rst_i,     // Sync reset, high
   input  wire logic [pmca_pkg::NUM_DED-1:0] ded_i,     // Dedicated inputs
   input  wire logic                         reg_clk_i, // Macrocell clock pin
   input  wire logic [pmca_pkg::NUM_MC-1:0]  pin_i,     // Pin levels in
   output logic      [pmca_pkg::NUM_MC-1:0]  pin_o,     // Pin drive value
   output logic      [pmca_pkg::NUM_MC-1:0]  pin_oe_o,  // Pin drive enable
   input  wire logic                         cyc_i,     // Wishbone cycle
   input  wire logic                         stb_i,     // Wishbone strobe
   input  wire logic                         we_i,      // Write enable
   input  wire logic [11:0]                  adr_i,     // Byte address
   input  wire logic [3:0]                   sel_i,     // Byte lanes
   input  wire logic [31:0]                  dat_i,     // Write data
   output logic      [31:0]                  dat_o,     // Read data
   output logic                              ack_o      // Acknowledge
);
   localparam int NT = pmca_pkg::NUM_TERM;
   localparam int TW = pmca_pkg::TERM_W;
   localparam int NM = pmca_pkg::NUM_MC;

   // Configuration store
   logic [TW-1:0]                 term_mem [pmca_pkg::MEM_DEPTH];
   logic [TW-1:0]                 next_term_mem [pmca_pkg::MEM_DEPTH];
   logic [pmca_pkg::CTRL_W-1:0]   ctrl [NM];
   logic [pmca_pkg::CTRL_W-1:0]   next_ctrl [NM];
   logic                          secure_open;
   logic                          next_secure_open;
   logic [NM-1:0]                 dyn_oe;
   logic [NM-1:0]                 next_dyn_oe;

   // Bus state
   logic                          next_ack;
   logic [31:0]                   next_dat;

   // Synchronisers and pin stage
   logic [pmca_pkg::NUM_DED-1:0]  ded_s1;
   logic [pmca_pkg::NUM_DED-1:0]  ded_s2;
   logic [NM-1:0]                 pin_s1;
   logic [NM-1:0]                 pin_s2;
   logic                          rclk_s1;
   logic                          rclk_s2;
   logic                          rclk_s3;
   logic                          reg_en;
   logic [NM-1:0]                 next_pin;
   logic [NM-1:0]                 next_pin_oe;

   logic [NM-1:0]                 mc_out;
   logic [NM-1:0]                 mc_fb;
   logic [pmca_pkg::NUM_VAR-1:0]  vars;
   logic [TW-1:0]                 lits;

   logic [9:0]                    idx;
   logic [5:0]                    mem_idx;
   logic [2:0]                    ctl_idx;
   logic [31:0]                   keep;
   logic [TW-1:0]                 keep_w;
   logic                          wr;

   assign idx     = adr_i[11:2];
   assign mem_idx = idx[6:1];
   assign ctl_idx = idx[2:0];
   assign wr      = cyc_i & stb_i & we_i & ack_o;
   assign reg_en  = rclk_s2 & ~rclk_s3;

   genvar k;
   generate
      for (k = 0; k < pmca_pkg::NUM_VAR; k++) begin : g_lit
         if (k < pmca_pkg::NUM_DED) begin : g_ded
            assign vars[k] = ded_s2[k];
         end else begin : g_fb
            assign vars[k] = mc_fb[k-pmca_pkg::NUM_DED];
         end
         assign lits[2*k]   = vars[k];
         assign lits[2*k+1] = ~vars[k];
      end
      for (k = 0; k < NM; k++) begin : g_mc
         logic [NT*TW-1:0] terms;
         for (genvar t = 0; t < NT; t++) begin : g_pack
            assign terms[t*TW +: TW] = term_mem[k*NT+t];
         end
         pmca_macrocell i_pmca_macrocell (
            .clk_i    (clk_i),
            .rst_i    (rst_i),
            .lit_i    (lits),
            .terms_i  (terms),
            .ctrl_i   (ctrl[k]),
            .reg_en_i (reg_en),
            .pin_fb_i (pin_s2[k]),
            .out_o    (mc_out[k]),
            .fb_o     (mc_fb[k])
         );
      end
   endgenerate

   // Pin driver: 11 output, 10 bidirectional under dyn_oe, 0x input
   always_comb begin
      next_pin = mc_out;
      for (int i = 0; i < NM; i++) begin
         if (ctrl[i][pmca_pkg::CTL_MODE_HI])
            next_pin_oe[i] = ctrl[i][pmca_pkg::CTL_MODE_LO] | dyn_oe[i];
         else
            next_pin_oe[i] = 1'b0;
      end
   end

   // Byte-lane mask: lanes not selected keep their bits
   always_comb begin
      keep = dat_i | ~{{8{sel_i[3]}}, {8{sel_i[2]}},
                       {8{sel_i[1]}}, {8{sel_i[0]}}};
      if (idx[0])
         keep_w = {keep[TW-33:0], {32{1'b1}}};
      else
         keep_w = {{(TW-32){1'b1}}, keep};
   end

   // Writes can only clear bits, except dyn_oe; only erase or reset sets them back
   always_comb begin
      next_term_mem    = term_mem;
      next_ctrl        = ctrl;
      next_secure_open = secure_open;
      next_dyn_oe      = dyn_oe;
      if (wr) begin
         if (idx <= pmca_pkg::IDX_TERM_LAST)
            next_term_mem[mem_idx] = term_mem[mem_idx] & keep_w;
         else if (idx >= pmca_pkg::IDX_CTRL_BASE &&
                  idx <= pmca_pkg::IDX_CTRL_LAST)
            next_ctrl[ctl_idx] = ctrl[ctl_idx]
                                 & keep[pmca_pkg::CTRL_W-1:0];
         else if (idx == pmca_pkg::IDX_SECURE)
            next_secure_open = secure_open & keep[0];
         else if (idx == pmca_pkg::IDX_DYN_OE && sel_i[0])
            next_dyn_oe = dat_i[NM-1:0];
         else if (idx == pmca_pkg::IDX_CMD && sel_i[0] &&
                  dat_i[pmca_pkg::CMD_ERASE]) begin
            for (int i = 0; i < pmca_pkg::MEM_DEPTH; i++)
               next_term_mem[i] = pmca_pkg::TERM_ERASED;
            for (int i = 0; i < NM; i++)
               next_ctrl[i] = pmca_pkg::CTRL_ERASED;
            next_secure_open = pmca_pkg::SEC_ERASED;
         end
      end
   end

   // Read side: array and control words read as zero while secured
   always_comb begin
      next_ack = cyc_i & stb_i & ~ack_o;
      next_dat = 32'h00000000;
      if (cyc_i & stb_i & ~we_i & ~ack_o) begin
         if (idx <= pmca_pkg::IDX_TERM_LAST) begin
            if (secure_open) begin
               if (idx[0])
                  next_dat = {{(64-TW){1'b0}}, term_mem[mem_idx][TW-1:32]};
               else
                  next_dat = term_mem[mem_idx][31:0];
            end
         end else if (idx >= pmca_pkg::IDX_CTRL_BASE &&
                      idx <= pmca_pkg::IDX_CTRL_LAST) begin
            if (secure_open)
               next_dat = {{(32-pmca_pkg::CTRL_W){1'b0}}, ctrl[ctl_idx]};
         end else if (idx == pmca_pkg::IDX_SECURE)
            next_dat = {31'h00000000, secure_open};
         else if (idx == pmca_pkg::IDX_DYN_OE)
            next_dat = {24'h000000, dyn_oe};
         else if (idx == pmca_pkg::IDX_STATUS)
            next_dat = {16'h0000, mc_out, pin_s2};
      end
   end

   // Reset returns the store to its erased image
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < pmca_pkg::MEM_DEPTH; i++)
            term_mem[i] <= pmca_pkg::TERM_ERASED;
         for (int i = 0; i < NM; i++)
            ctrl[i] <= pmca_pkg::CTRL_ERASED;
         secure_open <= pmca_pkg::SEC_ERASED;
         dyn_oe      <= pmca_pkg::DYN_OE_RST;
      end else begin
         term_mem    <= next_term_mem;
         ctrl        <= next_ctrl;
         secure_open <= next_secure_open;
         dyn_oe      <= next_dyn_oe;
      end
   end

   // Bus answer leaves on flops; data is zero outside the ack cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

   // Pin stage and two-flop synchronisers for the async inputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o       <= '0;
         pin_oe_o    <= '0;
         ded_s1      <= '0;
         ded_s2      <= '0;
         pin_s1      <= '0;
         pin_s2      <= '0;
         rclk_s1     <= 1'b0;
         rclk_s2     <= 1'b0;
         rclk_s3     <= 1'b0;
      end else begin
         pin_o       <= next_pin;
         pin_oe_o    <= next_pin_oe;
         ded_s1      <= ded_i;
         ded_s2      <= ded_s1;
         pin_s1      <= pin_i;
         pin_s2      <= pin_s1;
         rclk_s1     <= reg_clk_i;
         rclk_s2     <= rclk_s1;
         rclk_s3     <= rclk_s2;
      end
   end
endmodule

// File: pmca_top_monitor.sv
// Checker for the macrocell array bus and pin ports
`timescale 1ns/1ps
module pmca_top_monitor (
   input wire logic        clk_i,    // Clock
   input wire logic        rst_i,    // Reset
   input wire logic [7:0]  pin_oe_o, // Pin enable
   input wire logic        cyc_i,    // Cycle
   input wire logic        stb_i,    // Strobe
   input wire logic        we_i,     // Write
   input wire logic [11:0] adr_i,    // Address
   input wire logic [3:0]  sel_i,    // Lanes
   input wire logic [31:0] dat_i,    // Write data
   input wire logic [31:0] dat_o,    // Read data
   input wire logic        ack_o     // Acknowledge
);
   logic secured;
   logic next_secured;
   logic wr;
   assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   // Shadow of the lock, so hidden reads can be judged
   always_comb begin
      next_secured = secured;
      if (wr && adr_i[11:2] == pmca_pkg::IDX_SECURE && !dat_i[0])
         next_secured = 1'b1;
      if (wr && adr_i[11:2] == pmca_pkg::IDX_CMD && dat_i[0])
         next_secured = 1'b0;
      if (rst_i)
         next_secured = 1'b0;
   end
   always_ff @(posedge clk_i) begin
      secured <= next_secured;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      cyc_i && stb_i && !ack_o;
   endsequence
   sequence s_rd;
      ack_o && !we_i;
   endsequence
   a_ack_on_req: assert property (s_req |=> ack_o)
      else $error("request not acknowledged");
   a_ack_pulse: assert property (ack_o |=> !ack_o)
      else $error("ack held too long");
   a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
      else $error("ack without request");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_secure_hide: assert property (
      s_rd ##0 (secured && adr_i < 12'h220) |-> dat_o == 32'h0)
      else $error("secured contents readable");
   a_lock_state: assert property (
      s_rd ##0 adr_i[11:2] == pmca_pkg::IDX_SECURE |-> dat_o[0] == !secured)
      else $error("security word wrong");
   a_unmapped_zero: assert property (
      s_rd ##0 adr_i[11:2] > pmca_pkg::IDX_STATUS |-> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (disable iff (1'b0)
      rst_i |=> !ack_o && pin_oe_o == 8'h00) else $error("reset not quiet");
   a_erased_oe: assert property ($fell(rst_i)
      |-> ##[1:3] pin_oe_o == 8'hFF) else $error("erased pins not output");
endmodule
bind pmca_top pmca_top_monitor i_pmca_top_monitor (.clk_i, .rst_i, .pin_oe_o,
   .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o);

// File: pmca_board.sv
// Board around the pins: resolves each wire from both drivers
`timescale 1ns/1ps
module pmca_board (
   input  wire logic       clk_i,   // Clock
   input  wire logic [7:0] dev_i,   // Device value
   input  wire logic [7:0] dev_oe_i, // Device enable
   input  wire logic [7:0] brd_i,   // Board value
   input  wire logic [7:0] brd_en_i, // Board enable
   output logic      [7:0] pin_o    // Wire level
);
   logic [7:0] last;
   // Floating wire flips, so a stale level never passes
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         if (dev_oe_i[b])
            pin_o[b] = dev_i[b];
         else if (brd_en_i[b])
            pin_o[b] = brd_i[b];
         else
            pin_o[b] = ~last[b];
      end
   end
   always_ff @(posedge clk_i) begin
      last <= pin_o;
   end
endmodule

// File: pmca_top_test.sv
// Self-checking bench for the macrocell array top
`timescale 1ns/1ps
module pmca_top_test;
   logic        clk_i, rst_i, cyc, stb, we, ack, rclk;
   logic [9:0]  ded;
   logic [7:0]  pin_in, pin_o, pin_oe, brd, brd_en;
   logic [11:0] adr;
   logic [3:0]  sel, lanes;
   logic [31:0] dat_w, dat_r, q;
   int          mismatches, checks_done, cycles;
   pmca_top i_pmca_top (.clk_i, .rst_i, .ded_i(ded), .reg_clk_i(rclk),
      .pin_i(pin_in), .pin_o, .pin_oe_o(pin_oe), .cyc_i(cyc), .stb_i(stb),
      .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r),
      .ack_o(ack));
   pmca_board i_pmca_board (.clk_i, .dev_i(pin_o), .dev_oe_i(pin_oe),
      .brd_i(brd), .brd_en_i(brd_en), .pin_o(pin_in));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   task automatic close_out;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= lanes;
      dat_w <= d;
      // No fixed wait: only the cycle ceiling ends a missing answer
      do
         @(posedge clk_i);
      while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk(q, e);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Shared clock pin held long enough for the input synchroniser
   task automatic pulse;
      rclk <= 1'b1;
      wait_n(4);
      rclk <= 1'b0;
      wait_n(8);
   endtask
   task automatic t_erased;
      for (int m = 0; m < 8; m++) begin
         rd(12'(12'h200 + m * 4), 32'h7F);
         rd(12'(m * 64), 32'hFFFFFFFF);
         rd(12'(m * 64 + 60), 32'hF);
      end
      chk({24'h0, pin_oe}, 32'hFF);
      chk({24'h0, pin_o}, 32'hFF);
      $display("erased image done");
   endtask
   task automatic t_comb;
      wb(1'b1, 12'h000, 32'h1);
      wb(1'b1, 12'h004, 32'h0);
      ded <= 10'h001;
      wait_n(8);
      chk({24'h0, pin_o}, 32'hFE);
      ded <= 10'h000;
      wait_n(8);
      chk({24'h0, pin_o}, 32'hFF);
      wb(1'b1, 12'h000, 32'hFFFFFFFF);
      rd(12'h000, 32'h1);
      $display("combinational done");
   endtask
   task automatic t_reg;
      wb(1'b1, 12'h200, 32'h7E);
      ded <= 10'h001;
      wait_n(8);
      pulse();
      chk(32'(pin_o[0]), 32'h0);
      ded <= 10'h000;
      wait_n(8);
      chk(32'(pin_o[0]), 32'h0);
      pulse();
      chk(32'(pin_o[0]), 32'h1);
      wb(1'b1, 12'h200, 32'h7C);
      wait_n(8);
      chk(32'(pin_o[0]), 32'h0);
      $display("registered done");
   endtask
   task automatic t_pins;
      wb(1'b1, 12'h204, 32'h1F);
      wb(1'b1, 12'h208, 32'h5F);
      wb(1'b1, 12'h248, 32'hFB);
      // Cell 3 sums the true feedback of cell 1 alone
      wb(1'b1, 12'h0C0, 32'h00400000);
      wb(1'b1, 12'h0C4, 32'h0);
      wait_n(6);
      chk({24'h0, pin_oe}, 32'hF9);
      brd_en <= 8'h02;
      for (int v = 0; v < 2; v++) begin
         brd <= 8'(v * 2);
         wait_n(6);
         wb(1'b0, 12'h24C, 32'h0);
         chk(32'(q[1]), 32'(v));
         chk(32'(pin_o[3]), 32'(1 - v));
      end
      wb(1'b1, 12'h248, 32'hFF);
      wait_n(6);
      chk({24'h0, pin_oe}, 32'hFD);
      $display("pin modes done");
   endtask
   task automatic t_secure;
      // Lane 0 left out: the lock must stay open
      lanes = 4'h2;
      wb(1'b1, 12'h244, 32'h0);
      lanes = 4'hF;
      rd(12'h244, 32'h1);
      wb(1'b1, 12'h244, 32'h0);
      rd(12'h244, 32'h0);
      rd(12'h000, 32'h0);
      rd(12'h200, 32'h0);
      rd(12'h3F0, 32'h0);
      wb(1'b1, 12'h240, 32'h1);
      wait_n(6);
      rd(12'h244, 32'h1);
      rd(12'h000, 32'hFFFFFFFF);
      rd(12'h204, 32'h7F);
      chk({24'h0, pin_oe}, 32'hFF);
      $display("security done");
   endtask
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      {cyc, stb, we, rclk, ded, brd, brd_en, adr, sel, dat_w} = '0;
      lanes = 4'hF;
      rst_i = 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_erased();
      t_comb();
      t_reg();
      t_pins();
      t_secure();
      close_out();
   end
endmodule
